// *** verilog/hlp_host_map.svh ***
// Named constants of the host local bus port
`ifndef HLP_HOST_MAP_SVH
`define HLP_HOST_MAP_SVH
`define HLP_PHASE_ONE 1'b0
`define HLP_PHASE_TWO 1'b1
`define HLP_ADDR_RST 23'h000000
`define HLP_DATA_RST 16'h0000
`define HLP_BE_NONE 2'h3
`define HLP_ACT_N 1'b0
`define HLP_IDLE_N 1'b1
`define HLP_BIT_ON 1'b1
`define HLP_BIT_OFF 1'b0
`define HLP_OUT_ZERO 2'h0
`define HLP_OUT_ONE 2'h1
`define HLP_OUT_TWO 2'h2
`endif

// *** verilog/hlp_pkg.sv ***
// Types shared by the host local bus port
package hlp_pkg;
  typedef struct packed {
    logic [23:1] addr;
    logic [1:0] be_n;
    logic wr;
    logic mio;
    logic dc;
    logic [15:0] data;
  } hlp_cyc_t;

  typedef struct packed {
    logic [23:1] addr;
    logic [15:0] data;
    logic [1:0] be_n;
    logic dc;
    logic wr;
    logic mio;
    logic ads_n;
    logic ready_n;
    logic na_n;
    logic hold_ack;
    logic sel;
  } hlp_pins_t;

  typedef enum logic [4:0] {
    HLP_M_IDLE = 5'h01,
    HLP_M_HOLD = 5'h02,
    HLP_M_ADDR = 5'h04,
    HLP_M_DATA = 5'h08,
    HLP_M_REL = 5'h10
  } hlp_mst_state_t;
endpackage

// *** verilog/hlp_sync.sv ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module hlp_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [W-1:0] pin_in,
  input wire logic [W-1:0] rst_val,
  output logic [W-1:0] pin_out
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] out_reg;
  logic [W-1:0] out_next;

  // Bits take their new value only where stages two and three agree
  always_comb begin
    out_next = ((s2_reg ~^ s3_reg) & s2_reg) | ((s2_reg ^ s3_reg) & out_reg);
  end

  // All stages reset to the idle level, so release brings no false edge
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s1_reg <= rst_val;
      s2_reg <= rst_val;
      s3_reg <= rst_val;
      out_reg <= rst_val;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign pin_out = out_reg;
endmodule

// *** verilog/hlp_host_port.sv ***
// Local bus host port: slave tracking and hold-based master cycles
//
// Functional notes
// RULE_01 - Separate address and data buses toward host
// RULE_02 - Drive data only intack, slave read, master
// RULE_03 - Byte enables mark active data bytes
// RULE_04 - All logic on double-rate clock, phase tracked
// RULE_05 - Data/control line driven only in master mode
// RULE_06 - Write/read line driven only in master mode
// RULE_07 - Memory/IO line driven only in master mode
// RULE_08 - Address strobe first valid state, master only
// RULE_09 - Next address request honoured in master only
// RULE_10 - Slave pipelining from strobe and ready history
// RULE_11 - Request bus with active-high hold request
// RULE_12 - Owner acknowledges hold after releasing bus
// RULE_13 - Master cycles only after hold acknowledge
// RULE_14 - Hold kept whole tenure, release then drop
`timescale 1ns/1ps
`include "hlp_host_map.svh"
module hlp_host_port
  import hlp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [23:1] addr_lines_i,
  output logic [23:1] addr_lines_o,
  output logic addr_lines_oe,
  input wire logic [15:0] data_lines_i,
  output logic [15:0] data_lines_o,
  output logic data_lines_oe,
  input wire logic high_byte_en_n_i,
  input wire logic low_byte_en_n_i,
  output logic high_byte_en_n_o,
  output logic low_byte_en_n_o,
  output logic byte_en_oe,
  input wire logic data_ctrl_i,
  input wire logic write_read_i,
  input wire logic mem_io_i,
  output logic data_ctrl_o,
  output logic write_read_o,
  output logic mem_io_o,
  output logic cyc_def_oe,
  input wire logic addr_strobe_n_i,
  output logic addr_strobe_n_o,
  output logic addr_strobe_oe,
  input wire logic ready_n_i,
  input wire logic next_addr_req_n_i,
  output logic hold_req,
  input wire logic hold_ack_i,
  input wire logic slv_sel,
  input wire logic [15:0] slv_rdata,
  input wire logic [15:0] ack_vector,
  output hlp_cyc_t slv_cmd,
  output logic slv_strobe,
  output logic slv_pipe,
  output logic slv_done,
  input wire hlp_cyc_t mst_cmd,
  input wire logic mst_valid,
  output logic mst_ready,
  output logic [15:0] mst_rdata,
  output logic mst_done,
  output logic master_mode,
  output logic bus_phase
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  hlp_pins_t pins_raw;
  hlp_pins_t pins;
  hlp_pins_t pins_rst;

  always_comb begin
    pins_raw.addr = addr_lines_i;
    pins_raw.data = data_lines_i;
    pins_raw.be_n = {high_byte_en_n_i, low_byte_en_n_i};
    pins_raw.dc = data_ctrl_i;
    pins_raw.wr = write_read_i;
    pins_raw.mio = mem_io_i;
    pins_raw.ads_n = addr_strobe_n_i;
    pins_raw.ready_n = ready_n_i;
    pins_raw.na_n = next_addr_req_n_i;
    pins_raw.hold_ack = hold_ack_i;
    pins_raw.sel = slv_sel;
    pins_rst = '0;
    pins_rst.be_n = `HLP_BE_NONE;
    pins_rst.ads_n = `HLP_IDLE_N;
    pins_rst.ready_n = `HLP_IDLE_N;
    pins_rst.na_n = `HLP_IDLE_N;
  end

  // Each line is filtered alone, so a skewed bus may settle over a few edges
  hlp_sync #(.W($bits(hlp_pins_t))) u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pin_in(pins_raw),
    .rst_val(pins_rst),
    .pin_out(pins)
  );

  // ----------------------------------------------------------------
  // Phase tracking
  // ----------------------------------------------------------------
  logic phase_reg;
  logic phase_next;
  logic t_end;

  always_comb begin
    phase_next = ~phase_reg; // RULE_04
    t_end = (phase_reg == `HLP_PHASE_TWO); // RULE_04
  end

  // ----------------------------------------------------------------
  // Master sequencer
  // ----------------------------------------------------------------
  hlp_mst_state_t st_reg;
  hlp_mst_state_t st_next;
  hlp_cyc_t cur_reg;
  hlp_cyc_t cur_next;
  hlp_cyc_t nxt_reg;
  hlp_cyc_t nxt_next;
  logic pipe_reg;
  logic pipe_next;
  logic hold_reg;
  logic hold_next;
  logic ads_reg;
  logic ads_next;
  logic drive_reg;
  logic drive_next;
  logic done_reg;
  logic done_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic accept;

  always_comb begin
    st_next = st_reg;
    cur_next = cur_reg;
    nxt_next = nxt_reg;
    pipe_next = pipe_reg;
    hold_next = hold_reg;
    ads_next = ads_reg;
    drive_next = drive_reg;
    done_next = `HLP_BIT_OFF;
    rdata_next = rdata_reg;
    accept = `HLP_BIT_OFF;
    if (t_end) begin
      ads_next = `HLP_BIT_OFF;
      case (st_reg)
        HLP_M_IDLE: begin
          if (mst_valid && !pins.hold_ack) begin // RULE_13
            hold_next = `HLP_BIT_ON; // RULE_11
            st_next = HLP_M_HOLD;
          end
        end
        HLP_M_HOLD: begin
          if (pins.hold_ack) begin // RULE_12 RULE_13
            accept = `HLP_BIT_ON;
            cur_next = mst_cmd;
            ads_next = `HLP_BIT_ON; // RULE_08
            drive_next = `HLP_BIT_ON;
            st_next = HLP_M_ADDR;
          end
        end
        HLP_M_ADDR: begin
          st_next = HLP_M_DATA;
        end
        HLP_M_DATA: begin
          if (pins.ready_n == `HLP_ACT_N) begin
            done_next = `HLP_BIT_ON;
            rdata_next = pins.data;
            if (pipe_reg) begin
              cur_next = nxt_reg;
              pipe_next = `HLP_BIT_OFF;
            end else if (mst_valid) begin
              accept = `HLP_BIT_ON;
              cur_next = mst_cmd;
              ads_next = `HLP_BIT_ON; // RULE_08
              st_next = HLP_M_ADDR;
            end else begin
              drive_next = `HLP_BIT_OFF; // RULE_14
              st_next = HLP_M_REL;
            end
          end else if (pins.na_n == `HLP_ACT_N && !pipe_reg && mst_valid) begin // RULE_09
            accept = `HLP_BIT_ON;
            nxt_next = mst_cmd;
            pipe_next = `HLP_BIT_ON;
            ads_next = `HLP_BIT_ON;
          end
        end
        HLP_M_REL: begin
          hold_next = `HLP_BIT_OFF; // RULE_14
          st_next = HLP_M_IDLE;
        end
        default: begin
          st_next = HLP_M_IDLE;
          hold_next = `HLP_BIT_OFF;
          drive_next = `HLP_BIT_OFF;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Slave tracking
  // ----------------------------------------------------------------
  logic [1:0] open_reg;
  logic [1:0] open_next;
  logic prev_ads_reg;
  logic prev_ads_next;
  hlp_cyc_t scmd_reg;
  hlp_cyc_t scmd_next;
  logic sstb_reg;
  logic sstb_next;
  logic spipe_reg;
  logic spipe_next;
  logic sdone_reg;
  logic sdone_next;
  logic ads_now;
  logic rdy_now;
  logic intack;

  always_comb begin
    open_next = open_reg;
    prev_ads_next = prev_ads_reg;
    scmd_next = scmd_reg;
    sstb_next = `HLP_BIT_OFF;
    spipe_next = spipe_reg;
    sdone_next = `HLP_BIT_OFF;
    ads_now = (pins.ads_n == `HLP_ACT_N);
    rdy_now = (pins.ready_n == `HLP_ACT_N) && (open_reg != `HLP_OUT_ZERO);
    if (t_end && !drive_reg) begin
      prev_ads_next = ads_now;
      sdone_next = rdy_now;
      if (ads_now && !prev_ads_reg) begin
        scmd_next.addr = pins.addr;
        scmd_next.be_n = pins.be_n; // RULE_03
        scmd_next.wr = pins.wr; // RULE_06
        scmd_next.mio = pins.mio; // RULE_07
        scmd_next.dc = pins.dc; // RULE_05
        scmd_next.data = pins.data;
        sstb_next = `HLP_BIT_ON;
        // A strobe before the open cycle's ready means a pipelined address
        spipe_next = (open_reg != `HLP_OUT_ZERO) && !rdy_now; // RULE_10
      end
      if (ads_now && !prev_ads_reg && !rdy_now) begin
        open_next = (open_reg == `HLP_OUT_ZERO) ? `HLP_OUT_ONE : `HLP_OUT_TWO; // RULE_10
      end else if (!(ads_now && !prev_ads_reg) && rdy_now) begin
        open_next = (open_reg == `HLP_OUT_TWO) ? `HLP_OUT_ONE : `HLP_OUT_ZERO; // RULE_10
      end
    end
    intack = !scmd_next.dc && !scmd_next.mio && !scmd_next.wr;
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  hlp_cyc_t show;
  logic [15:0] dout_next;
  logic doe_next;
  logic [15:0] dout_reg;
  logic doe_reg;

  always_comb begin
    show = pipe_next ? nxt_next : cur_next;
    dout_next = intack ? ack_vector : slv_rdata;
    doe_next = `HLP_BIT_OFF;
    if (drive_next) begin
      dout_next = cur_next.data;
      doe_next = cur_next.wr; // RULE_02
    end else if (open_next != `HLP_OUT_ZERO && !scmd_next.wr) begin
      doe_next = pins.sel || intack; // RULE_02
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      phase_reg <= `HLP_PHASE_ONE;
      st_reg <= HLP_M_IDLE;
      cur_reg <= '0;
      nxt_reg <= '0;
      pipe_reg <= `HLP_BIT_OFF;
      hold_reg <= `HLP_BIT_OFF;
      ads_reg <= `HLP_BIT_OFF;
      drive_reg <= `HLP_BIT_OFF;
      done_reg <= `HLP_BIT_OFF;
      rdata_reg <= `HLP_DATA_RST;
      open_reg <= `HLP_OUT_ZERO;
      prev_ads_reg <= `HLP_BIT_OFF;
      scmd_reg <= '0;
      sstb_reg <= `HLP_BIT_OFF;
      spipe_reg <= `HLP_BIT_OFF;
      sdone_reg <= `HLP_BIT_OFF;
      dout_reg <= `HLP_DATA_RST;
      doe_reg <= `HLP_BIT_OFF;
    end else begin
      phase_reg <= phase_next;
      st_reg <= st_next;
      cur_reg <= cur_next;
      nxt_reg <= nxt_next;
      pipe_reg <= pipe_next;
      hold_reg <= hold_next;
      ads_reg <= ads_next;
      drive_reg <= drive_next;
      done_reg <= done_next;
      rdata_reg <= rdata_next;
      open_reg <= open_next;
      prev_ads_reg <= prev_ads_next;
      scmd_reg <= scmd_next;
      sstb_reg <= sstb_next;
      spipe_reg <= spipe_next;
      sdone_reg <= sdone_next;
      dout_reg <= dout_next;
      doe_reg <= doe_next;
    end
  end

  // Address and definition lines hold the current cycle until a pipelined one shows
  logic [23:1] aout_reg;
  logic [1:0] beout_reg;
  logic [2:0] defout_reg;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      aout_reg <= `HLP_ADDR_RST;
      beout_reg <= `HLP_BE_NONE;
      defout_reg <= '0;
    end else begin
      aout_reg <= show.addr; // RULE_01
      beout_reg <= show.be_n; // RULE_03
      defout_reg <= {show.dc, show.wr, show.mio};
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign addr_lines_o = aout_reg;
  assign addr_lines_oe = drive_reg; // RULE_01
  assign data_lines_o = dout_reg;
  assign data_lines_oe = doe_reg; // RULE_02
  assign high_byte_en_n_o = beout_reg[1];
  assign low_byte_en_n_o = beout_reg[0];
  assign byte_en_oe = drive_reg; // RULE_03
  assign data_ctrl_o = defout_reg[2];
  assign write_read_o = defout_reg[1];
  assign mem_io_o = defout_reg[0];
  assign cyc_def_oe = drive_reg; // RULE_05 RULE_06 RULE_07
  assign addr_strobe_n_o = ~ads_reg; // RULE_08
  assign addr_strobe_oe = drive_reg; // RULE_08
  assign hold_req = hold_reg; // RULE_11 RULE_14
  assign slv_cmd = scmd_reg;
  assign slv_strobe = sstb_reg;
  assign slv_pipe = spipe_reg;
  assign slv_done = sdone_reg;
  assign mst_ready = accept;
  assign mst_rdata = rdata_reg;
  assign mst_done = done_reg;
  assign master_mode = drive_reg;
  assign bus_phase = phase_reg;
endmodule

// *** testbench/hlp_host_port_assertions.sv ***
// Checker of pin ownership and master handshakes of the host port
`timescale 1ns/1ps
module hlp_host_port_assertions (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic addr_lines_oe,
  input wire logic data_lines_oe,
  input wire logic byte_en_oe,
  input wire logic cyc_def_oe,
  input wire logic write_read_o,
  input wire logic addr_strobe_n_o,
  input wire logic hold_req,
  input wire logic hold_ack_i,
  input wire logic mst_ready,
  input wire logic master_mode,
  input wire logic bus_phase
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  // ----
  // Strobe shape
  // ----
  sequence s_low_tstate;
    master_mode && !addr_strobe_n_o ##1 !addr_strobe_n_o ##1 addr_strobe_n_o;
  endsequence
  // ----
  // Ownership and handshakes
  // ----
  a_addr_own: assert property (addr_lines_oe |-> master_mode)
    else $error("address bus driven outside master mode");
  a_def_own: assert property ((cyc_def_oe || byte_en_oe) |-> master_mode)
    else $error("cycle definition driven outside master mode");
  a_data_write: assert property (data_lines_oe && master_mode |-> write_read_o)
    else $error("master drives data on a read");
  a_strobe_len: assert property ($fell(addr_strobe_n_o) |-> s_low_tstate)
    else $error("address strobe not one bus state long");
  a_take_phase: assert property (mst_ready |-> bus_phase)
    else $error("command taken off the second phase");
  a_ack_first: assert property (master_mode |-> hold_ack_i)
    else $error("master mode without hold acknowledge");
  a_hold_tenure: assert property (master_mode |-> hold_req)
    else $error("hold request dropped in master mode");
  a_rel_drop: assert property ($fell(master_mode) |-> ##[1:6] !hold_req)
    else $error("hold request kept after release");
  a_hold_first: assert property ($rose(hold_req) |-> !master_mode)
    else $error("hold requested while already master");
  a_grant_fresh: assert property ($rose(hold_req) |-> !$past(hold_ack_i, 3))
    else $error("hold requested while the last grant still stands");
endmodule

// *** testbench/hlp_bus_partner.sv ***
// Far side model: bus owner granting hold, memory answering cycles
`timescale 1ns/1ps
module hlp_bus_partner #(
  parameter int WAITS = 3,
  parameter logic [15:0] RDATA = 16'hC3E1
) (
  input wire logic clk_sys,
  input wire logic hold_req,
  input wire logic ads_n,
  input wire logic ads_oe,
  output logic hold_ack,
  output logic ready_n,
  output logic [15:0] data
);
  logic [1:0] lag;
  int cnt;
  initial begin
    lag = 2'h0;
    cnt = 0;
    hold_ack = 1'b0;
    ready_n = 1'b1;
    data = ~RDATA;
  end
  // Grant lags the request: the owner first ends its own cycle
  always @(negedge clk_sys) begin
    lag <= {lag[0], hold_req};
    hold_ack <= lag[1];
    cnt <= (!ads_n && ads_oe) ? WAITS + 2 : (cnt > 0 ? cnt - 1 : 0);
    ready_n <= !(cnt == 1 || cnt == 2);
    data <= (cnt == 1 || cnt == 2) ? RDATA : ~RDATA;
  end
endmodule

// *** testbench/hlp_host_port_tb.sv ***
// Self-checking bench for the host local bus port
`timescale 1ns/1ps
module hlp_host_port_tb;
  import hlp_pkg::*;
  localparam logic [15:0] RD = 16'hC3E1;
  hlp_cyc_t mst_cmd, slv_cmd;
  logic clk_sys, sys_rst, mst_valid, slv_sel, ads, rdy, prdy, swr, smio, sdc;
  logic next_addr_req_n_i, hold_ack_i, addr_lines_oe, data_lines_oe, byte_en_oe;
  logic high_byte_en_n_o, low_byte_en_n_o, data_ctrl_o, write_read_o, mem_io_o;
  logic cyc_def_oe, addr_strobe_n_o, addr_strobe_oe, hold_req, slv_strobe, slv_pipe;
  logic slv_done, mst_ready, mst_done, master_mode, bus_phase;
  logic [23:1] addr_lines_o, sa;
  logic [15:0] data_lines_o, slv_rdata, ack_vector, mst_rdata, pdat;
  logic [1:0] sbe;
  int n_mismatch, num_checks, cyc;
  // Each enabled line takes the value of whoever enables it; ready is the AND of both sources
  wire [23:1] addr_lines_i = addr_lines_oe ? addr_lines_o : sa;
  wire [15:0] data_lines_i = data_lines_oe ? data_lines_o : pdat;
  wire high_byte_en_n_i = byte_en_oe ? high_byte_en_n_o : sbe[1];
  wire low_byte_en_n_i = byte_en_oe ? low_byte_en_n_o : sbe[0];
  wire data_ctrl_i = cyc_def_oe ? data_ctrl_o : sdc;
  wire write_read_i = cyc_def_oe ? write_read_o : swr;
  wire mem_io_i = cyc_def_oe ? mem_io_o : smio;
  wire addr_strobe_n_i = addr_strobe_oe ? addr_strobe_n_o : ads;
  wire ready_n_i = prdy & rdy;
  hlp_host_port dut_u (.*);
  hlp_bus_partner #(.RDATA(RD)) bus_u (.clk_sys(clk_sys), .hold_req(hold_req),
    .ads_n(addr_strobe_n_o), .ads_oe(addr_strobe_oe), .hold_ack(hold_ack_i),
    .ready_n(prdy), .data(pdat));
  // ----
  // Helpers
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic sig(input int k);
    case (k)
      0: return mst_ready;
      1: return mst_done;
      2: return slv_strobe;
      3: return slv_done;
      4: return hold_req;
      5: return !hold_req;
      default: return master_mode;
    endcase
  endfunction
  // Bounded wait, judged as a comparison
  task automatic wt(input int k);
    for (int i = 0; i < 60 && sig(k) !== 1'b1; i++) @(negedge clk_sys);
    chk(sig(k), 1);
  endtask
  task automatic stb;
    ads = 0;
    repeat (2) @(negedge clk_sys);
    ads = 1;
  endtask
  task automatic rdy2;
    rdy = 0;
    repeat (2) @(negedge clk_sys);
    rdy = 1;
    wt(3);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_master(input logic wr);
    mst_cmd = '{addr:23'h12345, be_n:2'h1, wr:wr, mio:1'b1, dc:1'b1, data:16'hA5C3};
    mst_valid = 1;
    wt(4);
    wt(0);
    chk(hold_ack_i, 1);
    @(negedge clk_sys);
    mst_valid = 0;
    wt(6);
    chk(addr_lines_o, 23'h12345);
    chk(addr_strobe_n_o, 0);
    chk({high_byte_en_n_o, low_byte_en_n_o}, 2'h1);
    chk({write_read_o, mem_io_o, data_ctrl_o}, {wr, 2'h3});
    chk(data_lines_oe, wr);
    if (wr) chk(data_lines_o, 16'hA5C3);
    wt(1);
    if (!wr) chk(mst_rdata, RD);
    wt(5);
    chk({addr_lines_oe, cyc_def_oe, addr_strobe_oe}, 0);
    $display("master cycle test done, write %0d", wr);
  endtask
  task automatic t_slave;
    sa = 23'h00ABC;
    sbe = 2'h2;
    slv_sel = 1;
    next_addr_req_n_i = 0;
    stb();
    wt(2);
    chk(slv_cmd.be_n, 2'h2);
    chk({slv_cmd.wr, slv_cmd.mio, slv_cmd.dc}, 3'h3);
    chk(slv_pipe, 0);
    chk(data_lines_o, 16'h5AA5);
    chk(data_lines_oe, 1);
    sa = 23'h00ABD;
    stb();
    wt(2);
    chk(slv_pipe, 1);
    chk(slv_cmd.addr, 23'h00ABD);
    chk(master_mode, 0);
    rdy2();
    rdy2();
    repeat (4) @(negedge clk_sys);
    chk(data_lines_oe, 0);
    next_addr_req_n_i = 1;
    $display("slave pipeline test done");
  endtask
  task automatic t_intack;
    {swr, smio, sdc} = 3'h0;
    slv_sel = 0;
    stb();
    wt(2);
    chk(data_lines_o, 16'h3C96);
    chk(data_lines_oe, 1);
    rdy2();
    {swr, smio, sdc} = 3'h7;
    slv_sel = 1;
    stb();
    wt(2);
    chk(slv_cmd.wr, 1);
    chk(data_lines_oe, 0);
    rdy2();
    $display("acknowledge and write test done");
  endtask
  // ----
  // Clock, timeout, sequence
  // ----
  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    sys_rst = 1;
    mst_valid = 0;
    mst_cmd = '0;
    slv_sel = 0;
    ads = 1;
    rdy = 1;
    {swr, smio, sdc} = 3'h3;
    sa = '0;
    sbe = 2'h3;
    next_addr_req_n_i = 1;
    slv_rdata = 16'h5AA5;
    ack_vector = 16'h3C96;
    n_mismatch = 0;
    num_checks = 0;
    cyc = 0;
    repeat (3) @(negedge clk_sys);
    sys_rst = 0;
    chk({hold_req, addr_strobe_n_o, data_lines_oe, bus_phase}, 4'h4);
    repeat (6) @(negedge clk_sys);
    t_master(1);
    t_master(0);
    t_slave();
    t_intack();
    print_verdict();
  end
endmodule
bind hlp_host_port hlp_host_port_assertions chk_u (.*);
